/* File: include/pmrb_pkg.sv */
// Constants for the per-port management register bank.
// Assumes a clause-22 style serial management frame on the pins.
package pmrb_pkg;

  // Register addresses (5-bit register field of the frame)
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_ID_HIGH = 5'h02;
  localparam logic [4:0] REG_ID_LOW = 5'h03;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_PARTNER = 5'h05;
  localparam logic [4:0] REG_CABLE = 5'h1d;
  localparam logic [4:0] REG_SPECIAL = 5'h1f;

  // Control register fields
  localparam int CTRL_SPEED_100 = 13;
  localparam int CTRL_NEG_ON = 12;
  localparam int CTRL_POWER_DOWN = 11;
  localparam int CTRL_ISOLATE = 10;
  localparam int CTRL_RESTART = 9;
  localparam int CTRL_FULL_DUPLEX = 8;
  localparam int CTRL_XOVER_VARIANT = 5;
  localparam int CTRL_STRAIGHT = 4;
  localparam int CTRL_XOVER_OFF = 3;
  localparam int CTRL_FAULT_OFF = 2;
  localparam int CTRL_TX_OFF = 1;
  localparam int CTRL_LED_OFF = 0;
  localparam logic [15:0] CTRL_RESET = 16'h3120;
  localparam logic [15:0] CTRL_WMASK = 16'h3d3f;

  // Status register fields
  localparam logic [15:0] STATUS_FIXED = 16'h7808;
  localparam int STATUS_NEG_DONE = 5;
  localparam int STATUS_FAULT = 4;
  localparam int STATUS_LINK = 2;

  // Advertisement register fields
  localparam int ADV_PAUSE = 10;
  localparam int ADV_100_FULL = 8;
  localparam int ADV_100_HALF = 7;
  localparam int ADV_10_FULL = 6;
  localparam int ADV_10_HALF = 5;
  localparam logic [15:0] ADV_RESET = 16'h0de1;
  localparam logic [15:0] ADV_WMASK = 16'h05e0;

  // Serial frame layout
  localparam int FRAME_PRE_LEN = 32;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [4:0] HDR_BITS = 5'd12;
  localparam logic [4:0] DATA_BITS = 5'd16;
  localparam logic [4:0] TA_BITS = 5'd2;

  // Frame engine states
  typedef enum logic [2:0] {
    ST_PRE = 3'b000,
    ST_START = 3'b001,
    ST_HDR = 3'b010,
    ST_TA_RD = 3'b011,
    ST_RD = 3'b100,
    ST_TA_WR = 3'b101,
    ST_WR = 3'b110
  } pmrb_state_t;

endpackage : pmrb_pkg

/* File: design/pmrb_sync.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk_in.
`timescale 1ns/1ps
module pmrb_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Pins and filtered result
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] lvl_r;
  logic [WIDTH-1:0] lvl_nxt;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      // Take a change only once stages two and three agree
      always_comb begin
        lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_out = lvl_r;
endmodule : pmrb_sync

/* File: design/pmrb_neg_ctl.sv */
// Negotiation restart flag and effective speed/duplex selection.
// Assumes request and result inputs are on clk_in.
`timescale 1ns/1ps
module pmrb_neg_ctl (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Control
  input wire logic restart_req_in,
  input wire logic neg_on_in,
  input wire logic forced_100_in,
  input wire logic forced_full_in,
  // Negotiated result
  input wire logic neg_100_in,
  input wire logic neg_full_in,
  // Outputs
  output logic restart_out,
  output logic speed_100_out,
  output logic full_duplex_out
);
  logic restart_r;
  logic restart_nxt;
  logic speed_r;
  logic speed_nxt;
  logic full_r;
  logic full_nxt;

  always_comb begin
    // Flag is the request registered one cycle late, so it stays high as long as the request and clears one cycle after the request drops
    restart_nxt = restart_req_in;
    if (neg_on_in) begin
      speed_nxt = neg_100_in;
      full_nxt = neg_full_in;
    end else begin
      speed_nxt = forced_100_in;
      full_nxt = forced_full_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      restart_r <= 1'b0;
      speed_r <= 1'b1;
      full_r <= 1'b1;
    end else begin
      restart_r <= restart_nxt;
      speed_r <= speed_nxt;
      full_r <= full_nxt;
    end
  end

  assign restart_out = restart_r;
  assign speed_100_out = speed_r;
  assign full_duplex_out = full_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_one_pulse;
    restart_out ##1 !restart_out;
  endsequence
  property p_restart;
    restart_req_in |=> s_one_pulse;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart pulse not one cycle");
  property p_forced_mode;
    !neg_on_in |=> speed_100_out == $past(forced_100_in) &&
      full_duplex_out == $past(forced_full_in);
  endproperty
  a_forced_mode: assert property (p_forced_mode)
    else $error("forced speed or duplex not applied");
endmodule : pmrb_neg_ctl

/* File: design/pmrb_top.sv */
// Per-port management register bank behind the serial management pins.
// Assumes management clock far below clk_in; transceiver inputs on clk_in.
`timescale 1ns/1ps
module pmrb_top
  import pmrb_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  // Arbitrary identifier values
  parameter logic [15:0] PHY_ID_HIGH = 16'h0a5c,
  parameter logic [15:0] PHY_ID_LOW = 16'h3c70
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Serial management pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // Transceiver state
  input wire logic negotiation_done_in,
  input wire logic far_fault_in,
  input wire logic link_up_in,
  input wire logic neg_speed_100_in,
  input wire logic neg_full_duplex_in,
  // Transceiver control
  output logic negotiation_on_out,
  output logic negotiation_restart_out,
  output logic power_down_out,
  output logic line_isolate_out,
  output logic speed_100_out,
  output logic full_duplex_out,
  output logic crossover_variant_select_out,
  output logic forced_straight_pairs_out,
  output logic crossover_auto_off_out,
  output logic far_fault_detect_off_out,
  output logic transmit_off_out,
  output logic led_off_out,
  // Advertised abilities
  output logic [15:0] advertisement_out
);

  function automatic logic reg_hit(input logic [4:0] a);
    reg_hit = (a <= REG_PARTNER) || (a == REG_CABLE) ||
              (a == REG_SPECIAL);
  endfunction : reg_hit
  logic [1:0] pins_lvl;
  logic mdc_lvl, mdio_lvl, mdc_q_r, mdc_rise;
  pmrb_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .pin_in({mdc_in, mdio_in}),
    .level_out(pins_lvl)
  );
  assign mdc_lvl = pins_lvl[1];
  assign mdio_lvl = pins_lvl[0];
  assign mdc_rise = mdc_lvl && !mdc_q_r;

  // Frame engine state
  pmrb_state_t st_r, st_nxt;
  logic [5:0] ones_r, ones_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [11:0] hdr_r, hdr_nxt;
  logic mdio_r, mdio_nxt;
  logic oe_r, oe_nxt;
  logic wr_stb_r, wr_stb_nxt;
  logic [4:0] wr_reg_r, wr_reg_nxt;
  logic [15:0] wr_data_r, wr_data_nxt;
  // Register state
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] adv_r, adv_nxt;
  logic [2:0] stat_r, stat_nxt;
  logic [15:0] ctrl_word, status_word, rd_word;
  logic [11:0] hdr_full;
  logic restart_flag;
  assign hdr_full = {hdr_r[10:0], mdio_lvl};

  always_comb begin
    ctrl_word = ctrl_r;
    ctrl_word[CTRL_RESTART] = restart_flag;
    status_word = STATUS_FIXED;
    status_word[STATUS_NEG_DONE] = stat_r[2];
    status_word[STATUS_FAULT] = stat_r[1];
    status_word[STATUS_LINK] = stat_r[0];
    case (hdr_full[4:0])
      REG_CTRL: rd_word = ctrl_word;
      REG_STATUS: rd_word = status_word;
      REG_ID_HIGH: rd_word = PHY_ID_HIGH;
      REG_ID_LOW: rd_word = PHY_ID_LOW;
      REG_ADV: rd_word = adv_r;
      default: rd_word = 16'h0000;
    endcase
  end
  always_comb begin
    st_nxt = st_r;
    ones_nxt = ones_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    hdr_nxt = hdr_r;
    mdio_nxt = mdio_r;
    oe_nxt = oe_r;
    wr_stb_nxt = 1'b0;
    wr_reg_nxt = wr_reg_r;
    wr_data_nxt = wr_data_r;
    if (mdc_rise) begin
      case (st_r)
        ST_PRE: begin
          if (mdio_lvl) begin
            if (ones_r != 6'(FRAME_PRE_LEN)) begin
              ones_nxt = ones_r + 6'd1;
            end
          end else begin
            ones_nxt = 6'd0;
            if (ones_r == 6'(FRAME_PRE_LEN)) begin
              st_nxt = ST_START;
            end
          end
        end
        ST_START: begin
          cnt_nxt = 5'd0;
          st_nxt = mdio_lvl ? ST_HDR : ST_PRE;
        end
        ST_HDR: begin
          hdr_nxt = hdr_full;
          cnt_nxt = cnt_r + 5'd1;
          if (cnt_r == HDR_BITS - 5'd1) begin
            cnt_nxt = 5'd0;
            st_nxt = ST_PRE;
            if (hdr_full[9:5] == PHY_ADDR && reg_hit(hdr_full[4:0])) begin
              if (hdr_full[11:10] == OP_READ) begin
                sh_nxt = rd_word;
                st_nxt = ST_TA_RD;
              end else if (hdr_full[11:10] == OP_WRITE) begin
                st_nxt = ST_TA_WR;
              end
            end
          end
        end
        ST_TA_RD: begin
          // Drive zero in the second turnaround bit
          oe_nxt = 1'b1;
          mdio_nxt = 1'b0;
          cnt_nxt = 5'd0;
          st_nxt = ST_RD;
        end
        ST_RD: begin
          if (cnt_r == DATA_BITS) begin
            oe_nxt = 1'b0;
            mdio_nxt = 1'b0;
            st_nxt = ST_PRE;
          end else begin
            mdio_nxt = sh_r[15];
            sh_nxt = {sh_r[14:0], 1'b0};
            cnt_nxt = cnt_r + 5'd1;
          end
        end
        ST_TA_WR: begin
          cnt_nxt = cnt_r + 5'd1;
          if (cnt_r == TA_BITS - 5'd1) begin
            cnt_nxt = 5'd0;
            st_nxt = ST_WR;
          end
        end
        ST_WR: begin
          sh_nxt = {sh_r[14:0], mdio_lvl};
          cnt_nxt = cnt_r + 5'd1;
          if (cnt_r == DATA_BITS - 5'd1) begin
            wr_stb_nxt = 1'b1;
            wr_reg_nxt = hdr_r[4:0];
            wr_data_nxt = {sh_r[14:0], mdio_lvl};
            st_nxt = ST_PRE;
          end
        end
        default: begin
          st_nxt = ST_PRE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end
  always_comb begin
    ctrl_nxt = ctrl_r;
    adv_nxt = adv_r;
    stat_nxt[2] = negotiation_done_in;
    stat_nxt[1] = far_fault_in && !ctrl_r[CTRL_FAULT_OFF];
    stat_nxt[0] = link_up_in;
    if (wr_stb_r && wr_reg_r == REG_CTRL) begin
      ctrl_nxt = (wr_data_r & CTRL_WMASK) | (ctrl_r & ~CTRL_WMASK);
    end
    if (wr_stb_r && wr_reg_r == REG_ADV) begin
      adv_nxt = (wr_data_r & ADV_WMASK) | (adv_r & ~ADV_WMASK);
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mdc_q_r <= 1'b0;
      st_r <= ST_PRE;
      ones_r <= 6'd0;
      cnt_r <= 5'd0;
      sh_r <= 16'h0000;
      hdr_r <= 12'h000;
      mdio_r <= 1'b0;
      oe_r <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_reg_r <= 5'h00;
      wr_data_r <= 16'h0000;
      ctrl_r <= CTRL_RESET;
      adv_r <= ADV_RESET;
      stat_r <= 3'b000;
    end else begin
      mdc_q_r <= mdc_lvl;
      st_r <= st_nxt;
      ones_r <= ones_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      hdr_r <= hdr_nxt;
      mdio_r <= mdio_nxt;
      oe_r <= oe_nxt;
      wr_stb_r <= wr_stb_nxt;
      wr_reg_r <= wr_reg_nxt;
      wr_data_r <= wr_data_nxt;
      ctrl_r <= ctrl_nxt;
      adv_r <= adv_nxt;
      stat_r <= stat_nxt;
    end
  end
  pmrb_neg_ctl u_neg (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .restart_req_in(wr_stb_r && wr_reg_r == REG_CTRL &&
                    wr_data_r[CTRL_RESTART]),
    .neg_on_in(ctrl_r[CTRL_NEG_ON]),
    .forced_100_in(ctrl_r[CTRL_SPEED_100]),
    .forced_full_in(ctrl_r[CTRL_FULL_DUPLEX]),
    .neg_100_in(neg_speed_100_in),
    .neg_full_in(neg_full_duplex_in),
    .restart_out(restart_flag),
    .speed_100_out(speed_100_out),
    .full_duplex_out(full_duplex_out)
  );
  assign mdio_out = mdio_r;
  assign mdio_oe_out = oe_r;
  assign negotiation_restart_out = restart_flag;
  assign negotiation_on_out = ctrl_r[CTRL_NEG_ON];
  assign power_down_out = ctrl_r[CTRL_POWER_DOWN];
  assign line_isolate_out = ctrl_r[CTRL_ISOLATE];
  assign crossover_variant_select_out = ctrl_r[CTRL_XOVER_VARIANT];
  assign forced_straight_pairs_out = ctrl_r[CTRL_STRAIGHT];
  assign crossover_auto_off_out = ctrl_r[CTRL_XOVER_OFF];
  assign far_fault_detect_off_out = ctrl_r[CTRL_FAULT_OFF];
  assign transmit_off_out = ctrl_r[CTRL_TX_OFF];
  assign led_off_out = ctrl_r[CTRL_LED_OFF];
  assign advertisement_out = adv_r;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_ctrl_wr; wr_stb_r && wr_reg_r == REG_CTRL; endsequence
  sequence s_rd_start; st_r == ST_TA_RD && mdc_rise; endsequence
  property p_reset_values;
    $past(srst_in) |-> negotiation_on_out && !power_down_out &&
      speed_100_out && full_duplex_out && crossover_variant_select_out &&
      !crossover_auto_off_out && !led_off_out && adv_r == ADV_RESET;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("control or advertisement reset value wrong");
  property p_ctrl_write;
    s_ctrl_wr |=> led_off_out == $past(wr_data_r[CTRL_LED_OFF]) &&
      transmit_off_out == $past(wr_data_r[CTRL_TX_OFF]) &&
      line_isolate_out == $past(wr_data_r[CTRL_ISOLATE]) &&
      forced_straight_pairs_out == $past(wr_data_r[CTRL_STRAIGHT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write not reflected on outputs");
  property p_status_fixed;
    status_word[15:11] == 5'h0f && status_word[3] && !status_word[0];
  endproperty
  a_status_fixed: assert property (p_status_fixed)
    else $error("fixed capability bits wrong");
  property p_status_track;
    1 |=> status_word[STATUS_NEG_DONE] == $past(negotiation_done_in) &&
      status_word[STATUS_LINK] == $past(link_up_in) &&
      status_word[STATUS_FAULT] ==
      ($past(far_fault_in) && !$past(ctrl_r[CTRL_FAULT_OFF]));
  endproperty
  a_status_track: assert property (p_status_track)
    else $error("status bits do not follow transceiver");
  property p_reserved_ignored;
    s_ctrl_wr |=> (ctrl_r & ~CTRL_WMASK) == 16'h0000;
  endproperty
  a_reserved_ignored: assert property (p_reserved_ignored)
    else $error("reserved control bits took a write");
  property p_adv_write;
    wr_stb_r && wr_reg_r == REG_ADV |=>
      (adv_r & ADV_WMASK) == ($past(wr_data_r) & ADV_WMASK) &&
      (adv_r & ~ADV_WMASK) == (ADV_RESET & ~ADV_WMASK);
  endproperty
  a_adv_write: assert property (p_adv_write)
    else $error("advertisement write wrong");
  property p_read_turnaround;
    s_rd_start |=> mdio_oe_out && !mdio_out;
  endproperty
  a_read_turnaround: assert property (p_read_turnaround)
    else $error("turnaround zero not driven");
endmodule : pmrb_top

/* File: bench/pmrb_mgmt_master.sv */
// Station management master model driving clause-22 style frames.
// Assumes the bench resolves the shared data wire with a pull-up.
`timescale 1ns/1ps
module pmrb_mgmt_master
  import pmrb_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Serial management pins
  input wire logic mdio_in,
  output logic mdc_out,
  output logic mdio_out,
  output logic mdio_oe_out,
  // Sampled turnaround bit and data word
  output logic [16:0] result_out,
  output logic result_vld_out
);
  localparam int HALF = 8;
  initial begin
    mdc_out = 1'b0;
    mdio_out = 1'b0;
    mdio_oe_out = 1'b0;
    result_out = 17'h00000;
    result_vld_out = 1'b0;
  end
  // One whole frame; management clock idles low outside it
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd);
    logic [63:0] bits;
    logic [63:0] smp;
    int nd;
    bits = {32'hffff_ffff, 2'b01, op, pa, ra, 2'b10, wd};
    nd = (op == OP_WRITE) ? 64 : 46;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_in);
      #1 mdc_out = 1'b0;
      mdio_oe_out = (i < nd);
      mdio_out = bits[63-i];
      repeat (HALF) @(posedge clk_in);
      #1 mdc_out = 1'b1;
      smp[63-i] = mdio_in;
      repeat (HALF - 1) @(posedge clk_in);
    end
    @(posedge clk_in);
    #1 mdc_out = 1'b0;
    mdio_oe_out = 1'b0;
    repeat (HALF) @(posedge clk_in);
    #1 result_out = smp[16:0];
    result_vld_out = 1'b1;
    @(posedge clk_in);
    #1 result_vld_out = 1'b0;
  endtask : frame
endmodule : pmrb_mgmt_master

/* File: bench/pmrb_top_tb.sv */
// Self-checking bench for the management register bank.
// Assumes the master model above and a pulled-up data wire.
`timescale 1ns/1ps
module pmrb_top_tb;
  import pmrb_pkg::*;
  localparam logic [4:0] ADDR = 5'h03;
  // Arbitrary identifier values
  localparam logic [15:0] IDH = 16'h2468;
  localparam logic [15:0] IDL = 16'h1357;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic mdc, mdio_m, mdio_m_oe, mdio_d, mdio_d_oe, mdio_w, vld, pulse;
  logic done_i = 1'b0, fault_i = 1'b0, link_i = 1'b0;
  logic n100 = 1'b1, nfull = 1'b1, oe_hit = 1'b0;
  logic [10:0] ctl;
  logic [15:0] adv, ctrl_m, d;
  logic [16:0] res;
  logic [18:0] e_pop;
  logic [18:0] exp_q[$];
  int err_total = 0, comparisons = 0, rst_cnt = 0, c0;
  assign mdio_w = mdio_d_oe ? mdio_d : (mdio_m_oe ? mdio_m : 1'b1);
  initial forever #25 clk_in = ~clk_in;
  pmrb_top #(.PHY_ADDR(ADDR), .PHY_ID_HIGH(IDH), .PHY_ID_LOW(IDL)) DUT (
    .clk_in(clk_in), .srst_in(srst_in), .mdc_in(mdc), .mdio_in(mdio_w),
    .mdio_out(mdio_d), .mdio_oe_out(mdio_d_oe),
    .negotiation_done_in(done_i), .far_fault_in(fault_i),
    .link_up_in(link_i), .neg_speed_100_in(n100),
    .neg_full_duplex_in(nfull), .negotiation_on_out(ctl[10]),
    .negotiation_restart_out(pulse), .power_down_out(ctl[9]),
    .line_isolate_out(ctl[8]), .speed_100_out(ctl[7]),
    .full_duplex_out(ctl[6]), .crossover_variant_select_out(ctl[5]),
    .forced_straight_pairs_out(ctl[4]), .crossover_auto_off_out(ctl[3]),
    .far_fault_detect_off_out(ctl[2]), .transmit_off_out(ctl[1]),
    .led_off_out(ctl[0]), .advertisement_out(adv));
  pmrb_mgmt_master u_mst (
    .clk_in(clk_in), .mdio_in(mdio_w), .mdc_out(mdc), .mdio_out(mdio_m),
    .mdio_oe_out(mdio_m_oe), .result_out(res), .result_vld_out(vld));
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // Expected {drove, drive at end, turnaround, data} noted per frame
  task automatic go(input logic [1:0] op, input logic [4:0] pa,
                    input logic [4:0] ra, input logic [15:0] wd,
                    input logic [18:0] e);
    exp_q.push_back(e);
    u_mst.frame(op, pa, ra, wd);
  endtask : go
  task automatic rd(input logic [4:0] ra, input logic [15:0] e);
    go(OP_READ, ADDR, ra, 16'h0000, {3'b100, e});
  endtask : rd
  task automatic wr(input logic [4:0] pa, input logic [4:0] ra,
                    input logic [15:0] wd);
    go(OP_WRITE, pa, ra, wd, {3'b000, wd});
  endtask : wr
  function automatic logic [18:0] ctl_exp(input logic [15:0] c);
    ctl_exp = {8'h00, c[12], c[11], c[10], c[12] ? n100 : c[13],
               c[12] ? nfull : c[8], c[5:0]};
  endfunction : ctl_exp
  function automatic logic [15:0] st_exp();
    st_exp = STATUS_FIXED | {10'h000, done_i, fault_i & ~ctrl_m[2], 1'b0,
                             link_i, 2'b00};
  endfunction : st_exp
  always @(posedge clk_in) begin
    if (pulse === 1'b1) rst_cnt++;
    if (vld === 1'b1) begin
      e_pop = exp_q.pop_front();
      check({oe_hit, mdio_d_oe, res}, e_pop);
      oe_hit = 1'b0;
    end else if (mdio_d_oe === 1'b1) begin
      oe_hit = 1'b1;
    end
  end
  initial begin
    #(100000 * 50);
    err_total++;
    end_sim();
  end
  initial begin
    logic [4:0] ra_t[8];
    logic [15:0] ex_t[8];
    void'($urandom(20065));
    ra_t = '{REG_CTRL, REG_STATUS, REG_ID_HIGH, REG_ID_LOW, REG_ADV,
             REG_PARTNER, REG_CABLE, REG_SPECIAL};
    ex_t = '{CTRL_RESET, STATUS_FIXED, IDH, IDL, ADV_RESET, 16'h0000,
             16'h0000, 16'h0000};
    repeat (8) @(posedge clk_in);
    #1 srst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1 ctrl_m = CTRL_RESET;
    check(ctl_exp(CTRL_RESET), {8'h00, ctl});
    check({3'b000, ADV_RESET}, {3'b000, adv});
    for (int i = 0; i < 8; i++) rd(ra_t[i], ex_t[i]);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++) begin
      d = (i == 7) ? 16'hffff : 16'($urandom());
      d[9] = i[0];
      n100 = 1'($urandom());
      nfull = 1'($urandom());
      c0 = rst_cnt;
      wr(ADDR, REG_CTRL, d);
      ctrl_m = d & CTRL_WMASK;
      check(ctl_exp(ctrl_m), {8'h00, ctl});
      check(19'(rst_cnt - c0), {18'h00000, d[9]});
      rd(REG_CTRL, ctrl_m);
    end
    n100 = 1'b1;
    nfull = 1'b1;
    @(posedge clk_in);
    #1 srst_in = 1'b1;
    repeat (8) @(posedge clk_in);
    #1 srst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1 ctrl_m = CTRL_RESET;
    check(ctl_exp(CTRL_RESET), {8'h00, ctl});
    rd(REG_CTRL, CTRL_RESET);
    $display("test control_writes done");
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 16'hffff : ((i == 1) ? 16'h0000 : 16'($urandom()));
      wr(ADDR, REG_ADV, d);
      d = (d & ADV_WMASK) | (ADV_RESET & ~ADV_WMASK);
      check({3'b000, d}, {3'b000, adv});
      rd(REG_ADV, d);
    end
    $display("test advertisement done");
    // Advertisement is writable, so it is left out here
    for (int i = 1; i < 8; i++) begin
      if (i != 4) wr(ADDR, ra_t[i], 16'($urandom()));
    end
    for (int i = 1; i < 8; i++) begin
      if (i != 4) rd(ra_t[i], ex_t[i]);
    end
    rd(REG_CTRL, ctrl_m);
    $display("test read_only_writes done");
    ctrl_m[2] = 1'b0;
    wr(ADDR, REG_CTRL, ctrl_m);
    for (int i = 0; i < 16; i++) begin
      if (i == 8) begin
        ctrl_m[2] = 1'b1;
        wr(ADDR, REG_CTRL, ctrl_m);
      end
      {done_i, fault_i, link_i} = 3'(i);
      rd(REG_STATUS, st_exp());
    end
    $display("test status done");
    go(OP_READ, ADDR + 5'h01, REG_CTRL, 16'h0000,
       {3'b001, 16'hffff});
    go(2'b00, ADDR, REG_CTRL, 16'h0000, {3'b001, 16'hffff});
    go(2'b11, ADDR, REG_CTRL, 16'h0000, {3'b001, 16'hffff});
    go(OP_READ, ADDR, 5'h06, 16'h0000, {3'b001, 16'hffff});
    go(OP_READ, ADDR, 5'h1e, 16'h0000, {3'b001, 16'hffff});
    wr(ADDR + 5'h01, REG_CTRL, 16'h0000);
    wr(ADDR, 5'h06, 16'h0000);
    rd(REG_CTRL, ctrl_m);
    check(ctl_exp(ctrl_m), {8'h00, ctl});
    $display("test refused_frames done");
    end_sim();
  end
endmodule : pmrb_top_tb
